// file: rtl/eeprom_pkg.sv
// Contract
// (RULE_01) Select low selects; high deselects into standby.
// (RULE_02) Running write completes; standby waits for it.
// (RULE_03) Deselected device keeps its output high impedance.
// (RULE_04) Select rise after valid write starts cycle.
// (RULE_05) Internal write cycle lasts at most 5 ms.
// (RULE_06) Sequences ignored until select seen low once.
// (RULE_07) Output updates after each falling clock edge.
// (RULE_08) Input bits captured on each rising edge.
// (RULE_09) Enabled protect pin low refuses status writes.
// (RULE_10) Protect pin ignored when protect enable clear.
// (RULE_11) Protect pin cannot disturb a started write.
// (RULE_12) Host keeps pause high when not pausing.
// (RULE_13) Pause suspends transfer and keeps partial state.
// (RULE_14) Pause lowered with clock high waits for fall.
// (RULE_15) Host keeps device selected throughout a pause.
// (RULE_16) Paused device ignores input, clock; output off.
// (RULE_17) Resume only when pause rises with clock low.
// (RULE_18) Pause low turns output off at once.
// (RULE_19) Write-in-progress flag is one while writing.
// (RULE_20) All fields travel most significant bit first.
// (RULE_21) Incomplete sequence dropped when select rises.
package eeprom_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 40_000_000;
  localparam int unsigned TWC_MS  = 5;
  localparam int unsigned TWC_CYC = (CLK_HZ / 1000) * TWC_MS;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int MEM_BYTES  = 8192;
  localparam int ADDR_W     = 13;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W     = 5;

  // ----------------------------------------------------------------------
  // Opcodes, sequence lengths in whole bytes and the last bit index
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [2:0] BYTES_OP   = 3'h1;
  localparam logic [2:0] BYTES_SR   = 3'h2;
  localparam logic [2:0] BYTES_HDR  = 3'h3;
  localparam logic [2:0] BYTES_DATA = 3'h4;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  // ----------------------------------------------------------------------
  // Status byte layout and reset values
  // ----------------------------------------------------------------------
  localparam int ST_PPE = 7;
  localparam int ST_BP1 = 3;
  localparam int ST_BP0 = 2;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;
  localparam logic       PPE_RST    = 1'b0;
  localparam logic [1:0] BP_RST     = 2'h0;

  typedef struct packed {
    logic       protect_pin_enable;
    logic [1:0] bp;
    logic       wel;
    logic       write_in_progress;
  } status_t;

  function automatic logic [7:0] status_byte(input status_t s);
    status_byte = {s.protect_pin_enable, 3'h0, s.bp, s.wel,
                   s.write_in_progress};
  endfunction : status_byte

  function automatic logic is_protected(input logic [1:0] bp,
                                        input logic [ADDR_W-1:0] a);
    is_protected = (bp == BP_ALL) || (bp == BP_HALF && a[ADDR_W-1]) ||
                   (bp == BP_QUARTER && (&a[ADDR_W-1:ADDR_W-2]));
  endfunction : is_protected

endpackage : eeprom_pkg

// file: rtl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST;
      q_ff    <= RST;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sync2

// file: rtl/write_timer.sv
`timescale 1ns/1ps
module write_timer #(
  parameter int unsigned CYC = 200000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          busy_ff;
  logic          nxt_busy;
  logic          done_ff;
  logic          nxt_done;

  // ----------------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (busy_ff) begin
      if (cnt_ff == CW'(CYC - 1)) begin // [RULE_05]
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_cnt  = '0;
      end else begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end else if (start) begin
      nxt_busy = 1'b1;
      nxt_cnt  = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

  property p_twc_max;
    @(posedge clk) disable iff (!rst_n) busy_ff |-> cnt_ff < CW'(CYC);
  endproperty
  a_twc_max: assert property (p_twc_max) // [RULE_05]
    else $error("write cycle ran past its limit");

  property p_done_ends;
    @(posedge clk) disable iff (!rst_n)
      done_ff |-> !busy_ff && $past(busy_ff);
  endproperty
  a_done_ends: assert property (p_done_ends) // [RULE_19]
    else $error("write flag not cleared at cycle end");

endmodule : write_timer

// file: rtl/serial_eeprom_pin_control.sv
`timescale 1ns/1ps
module serial_eeprom_pin_control
  import eeprom_pkg::*;
#(
  parameter int unsigned TWC_CYCLES = TWC_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      so_o,
  output logic      so_oe,
  output logic      standby
);

  // ----------------------------------------------------------------------
  // Link side, rising edge: capture of the incoming sequence
  // ----------------------------------------------------------------------
  logic                  link_rst_n;
  logic                  fresh_ff;
  logic                  acc_ff;
  logic                  nxt_acc;
  logic [2:0]            bit_ff;
  logic [2:0]            nxt_bit;
  logic [2:0]            bcnt_ff;
  logic [2:0]            nxt_bcnt;
  logic [2:0]            cur_bit;
  logic [2:0]            cur_bcnt;
  logic [7:0]            sh_ff;
  logic [7:0]            nxt_sh;
  logic [7:0]            op_ff;
  logic [7:0]            nxt_op;
  logic [7:0]            sr_ff;
  logic [7:0]            nxt_sr;
  logic [15:0]           addr_ff;
  logic [15:0]           nxt_addr;
  logic [PAGE_W-1:0]     widx_ff;
  logic [PAGE_W-1:0]     nxt_widx;
  logic [PAGE_BYTES-1:0] mask_ff;
  logic [PAGE_BYTES-1:0] nxt_mask;
  logic [7:0]            pbuf_ff [PAGE_BYTES];
  logic [7:0]            nxt_pbuf [PAGE_BYTES];
  logic                  tog_ff;
  logic                  nxt_tog;
  logic [7:0]            mem_ff [MEM_BYTES];

  assign link_rst_n = rst_n & ~cs_n;
  assign cur_bit    = fresh_ff ? bit_ff : 3'h0; // [RULE_21]
  assign cur_bcnt   = fresh_ff ? bcnt_ff : 3'h0; // [RULE_21]

  always_comb begin
    logic [PAGE_W-1:0] idx;
    idx      = addr_ff[PAGE_W-1:0] + (fresh_ff ? widx_ff : PAGE_W'(0));
    nxt_acc  = hold_n; // [RULE_16]
    nxt_bit  = bit_ff;
    nxt_bcnt = bcnt_ff;
    nxt_sh   = sh_ff;
    nxt_op   = op_ff;
    nxt_sr   = sr_ff;
    nxt_addr = addr_ff;
    nxt_tog  = tog_ff;
    nxt_widx = fresh_ff ? widx_ff : '0;
    nxt_mask = fresh_ff ? mask_ff : '0;
    nxt_pbuf = pbuf_ff;
    if (hold_n) begin // [RULE_13] [RULE_16]
      nxt_tog  = fresh_ff ? tog_ff : ~tog_ff;
      nxt_sh   = {sh_ff[6:0], si}; // [RULE_08] [RULE_20]
      nxt_bit  = cur_bit + 3'h1;
      nxt_bcnt = cur_bcnt;
      if (cur_bit == BIT_LAST) begin
        if (cur_bcnt != BYTES_DATA) begin
          nxt_bcnt = cur_bcnt + 3'h1;
        end
        if (cur_bcnt == 3'h0) begin
          nxt_op = nxt_sh;
        end else if (cur_bcnt == BYTES_OP) begin
          nxt_addr[15:8] = nxt_sh;
          nxt_sr         = nxt_sh;
        end else if (cur_bcnt == BYTES_SR) begin
          nxt_addr[7:0] = nxt_sh;
        end else if (op_ff == OP_WRITE) begin
          nxt_pbuf[idx] = nxt_sh;
          nxt_mask[idx] = 1'b1;
          nxt_widx      = nxt_widx + PAGE_W'(1);
        end
      end
    end
  end

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fresh_ff <= 1'b0;
      acc_ff   <= 1'b0;
    end else begin
      fresh_ff <= fresh_ff | hold_n;
      acc_ff   <= nxt_acc;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      bit_ff  <= 3'h0;
      bcnt_ff <= 3'h0;
      sh_ff   <= 8'h00;
      op_ff   <= 8'h00;
      sr_ff   <= 8'h00;
      addr_ff <= 16'h0000;
      widx_ff <= '0;
      mask_ff <= '0;
      tog_ff  <= 1'b0;
      pbuf_ff <= '{default: 8'h00};
    end else begin
      bit_ff  <= nxt_bit;
      bcnt_ff <= nxt_bcnt;
      sh_ff   <= nxt_sh;
      op_ff   <= nxt_op;
      sr_ff   <= nxt_sr;
      addr_ff <= nxt_addr;
      widx_ff <= nxt_widx;
      mask_ff <= nxt_mask;
      tog_ff  <= nxt_tog;
      pbuf_ff <= nxt_pbuf;
    end
  end

  // ----------------------------------------------------------------------
  // Link side, falling edge: pause state and serial output
  // ----------------------------------------------------------------------
  logic              paused;
  logic [7:0]        osh_ff;
  logic [7:0]        nxt_osh;
  logic              rd_on_ff;
  logic              nxt_rd_on;
  logic [ADDR_W-1:0] ptr_ff;
  logic [ADDR_W-1:0] nxt_ptr;
  logic [7:0]        st_link;
  logic [7:0]        st_byte;

  sync2 #(.W(8), .RST(8'h00)) u_st_sync (
    .clk   (sck),
    .rst_n (rst_n),
    .d     (st_byte),
    .q     (st_link)
  );

  always_comb begin
    logic [ADDR_W-1:0] a;
    a         = (cur_bcnt == BYTES_HDR) ? addr_ff[ADDR_W-1:0] : ptr_ff;
    nxt_osh   = osh_ff;
    nxt_rd_on = rd_on_ff;
    nxt_ptr   = ptr_ff;
    if (acc_ff) begin // [RULE_16]
      if (cur_bit == 3'h0 && op_ff == OP_RDSR && cur_bcnt >= BYTES_OP) begin
        nxt_osh   = st_link;
        nxt_rd_on = 1'b1;
      end else if (cur_bit == 3'h0 && op_ff == OP_READ &&
                   cur_bcnt >= BYTES_HDR) begin
        nxt_osh   = mem_ff[a];
        nxt_ptr   = a + ADDR_W'(1);
        nxt_rd_on = 1'b1;
      end else begin
        nxt_osh = {osh_ff[6:0], 1'b0}; // [RULE_07] [RULE_20]
      end
    end
  end

  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      osh_ff   <= 8'h00;
      rd_on_ff <= 1'b0;
      ptr_ff   <= '0;
    end else begin
      osh_ff   <= nxt_osh;
      rd_on_ff <= nxt_rd_on;
      ptr_ff   <= nxt_ptr;
    end
  end

  // Pause starts at once with the clock low, else at the next fall.
  // In the high phase only a rise taken before the pause keeps it running.
  assign paused = sck ? ~acc_ff : ~hold_n; // [RULE_14] [RULE_17]
  assign so_oe  = ~cs_n & hold_n & ~paused & rd_on_ff; // [RULE_03] [RULE_18]
  assign so_o   = osh_ff[7];

  // ----------------------------------------------------------------------
  // System side: reset release, pin crossing, sequence decode
  // ----------------------------------------------------------------------
  logic       rst_sync_n;
  logic       cs_s;
  logic       wp_s;
  logic       tog_s;
  logic       cs_prev_ff;
  logic       tog_seen_ff;
  logic       nxt_tog_seen;
  logic       armed_ff;
  logic       nxt_armed;
  logic       ppe_ff;
  logic       nxt_ppe;
  logic [1:0] bp_ff;
  logic [1:0] nxt_bp;
  logic       wel_ff;
  logic       nxt_wel;
  logic       standby_ff;
  logic       cs_rise;
  logic       frame_ok;
  logic       wrsr_ok;
  logic       write_ok;
  logic       start;
  logic       commit;
  logic       busy;
  logic       done;

  sync2 #(.W(1), .RST(1'b0)) u_rst_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_sync_n)
  );

  sync2 #(.W(3), .RST(3'b110)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .d     ({cs_n, wp_n, tog_ff}),
    .q     ({cs_s, wp_s, tog_s})
  );

  write_timer #(.CYC(TWC_CYCLES)) u_timer (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .start (start),
    .busy  (busy),
    .done  (done)
  );

  assign cs_rise  = cs_s & ~cs_prev_ff;
  assign frame_ok = cs_rise & armed_ff & (tog_s != tog_seen_ff) &
                    (bit_ff == 3'h0); // [RULE_06] [RULE_21]
  assign wrsr_ok  = frame_ok & (op_ff == OP_WRSR) & (bcnt_ff == BYTES_SR) &
                    wel_ff & ~busy;
  assign write_ok = frame_ok & (op_ff == OP_WRITE) &
                    (bcnt_ff == BYTES_DATA) & wel_ff & ~busy & (|mask_ff) &
                    ~is_protected(bp_ff, addr_ff[ADDR_W-1:0]);
  assign st_byte  = status_byte('{protect_pin_enable: ppe_ff, bp: bp_ff,
                                  wel: wel_ff,
                                  write_in_progress: busy}); // [RULE_19]

  always_comb begin
    nxt_tog_seen = cs_rise ? tog_s : tog_seen_ff;
    nxt_armed    = armed_ff | cs_rise; // [RULE_06]
    nxt_ppe      = ppe_ff;
    nxt_bp       = bp_ff;
    nxt_wel      = done ? 1'b0 : wel_ff;
    start        = 1'b0;
    commit       = 1'b0;
    if (frame_ok && bcnt_ff == BYTES_OP && op_ff == OP_WREN) begin
      nxt_wel = 1'b1;
    end else if (frame_ok && bcnt_ff == BYTES_OP && op_ff == OP_WRDI) begin
      nxt_wel = 1'b0;
    end
    // Protect pin is sampled only here, before any cycle starts.
    if (wrsr_ok && !(ppe_ff && !wp_s)) begin // [RULE_09] [RULE_10] [RULE_11]
      nxt_ppe = sr_ff[ST_PPE];
      nxt_bp  = {sr_ff[ST_BP1], sr_ff[ST_BP0]};
      start   = 1'b1; // [RULE_04]
    end else if (write_ok) begin
      start  = 1'b1; // [RULE_04] [RULE_05]
      commit = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cs_prev_ff  <= 1'b1;
      tog_seen_ff <= 1'b0;
      armed_ff    <= 1'b0;
      ppe_ff      <= PPE_RST;
      bp_ff       <= BP_RST;
      wel_ff      <= 1'b0;
      standby_ff  <= 1'b0;
    end else begin
      cs_prev_ff  <= cs_s;
      tog_seen_ff <= nxt_tog_seen;
      armed_ff    <= nxt_armed;
      ppe_ff      <= nxt_ppe;
      bp_ff       <= nxt_bp;
      wel_ff      <= nxt_wel;
      standby_ff  <= cs_s & ~busy & ~start; // [RULE_01] [RULE_02]
    end
  end

  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_ff[i]) begin
          mem_ff[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf_ff[i];
        end
      end
    end
  end

  assign standby = standby_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_desel_hiz;
    @(posedge clk) disable iff (!rst_sync_n) cs_n |-> !so_oe;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz) // [RULE_03]
    else $error("output driven while deselected");

  property p_pause_hiz;
    @(posedge clk) disable iff (!rst_sync_n) !hold_n |-> !so_oe;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) // [RULE_18]
    else $error("output driven while pause is low");

  property p_write_start;
    @(posedge clk) disable iff (!rst_sync_n) write_ok |=> busy;
  endproperty
  a_write_start: assert property (p_write_start) // [RULE_04]
    else $error("valid write did not start the cycle");

  property p_wp_refuse;
    @(posedge clk) disable iff (!rst_sync_n)
      (wrsr_ok && ppe_ff && !wp_s) |=> !busy && $stable(bp_ff);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) // [RULE_09]
    else $error("status write not refused by protect pin");

  property p_wp_ignored;
    @(posedge clk) disable iff (!rst_sync_n)
      (wrsr_ok && !ppe_ff) |=> busy && bp_ff == $past(sr_ff[3:2]);
  endproperty
  a_wp_ignored: assert property (p_wp_ignored) // [RULE_10]
    else $error("status write lost with protect disabled");

  property p_armed_first;
    @(posedge clk) disable iff (!rst_sync_n) $rose(busy) |-> $past(armed_ff);
  endproperty
  a_armed_first: assert property (p_armed_first) // [RULE_06]
    else $error("sequence accepted before first select low");

  property p_standby_wait;
    @(posedge clk) disable iff (!rst_sync_n)
      (cs_s && busy) |=> !standby;
  endproperty
  a_standby_wait: assert property (p_standby_wait) // [RULE_02]
    else $error("standby entered during write cycle");

  property p_capture_rise;
    @(posedge sck) disable iff (!rst_n)
      hold_n |=> sh_ff[0] == $past(si);
  endproperty
  a_capture_rise: assert property (p_capture_rise) // [RULE_08]
    else $error("input bit not captured on rising edge");

  property p_pause_freeze;
    @(posedge sck) disable iff (!link_rst_n) !hold_n |=> $stable(osh_ff);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) // [RULE_16]
    else $error("output shifted while paused");

endmodule : serial_eeprom_pin_control

// file: tb/spi_host.sv
`timescale 1ns/1ps
module spi_host (
  output logic       sck,
  output logic       cs_n,
  output logic       si,
  output logic       hold_n,
  input  wire logic  so,
  output logic [7:0] rx_byte,
  output logic       rx_done
);

  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------------
  task automatic sel();
    cs_n = 1'b0;
    #32;
  endtask : sel

  task automatic frame_end();
    #32 cs_n = 1'b1;
    si = ~si;
  endtask : frame_end

  // Pulses while paused, then resume with the clock low.
  task automatic junk();
    repeat (2) begin
      si = ~si;
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #16 hold_n = 1'b1;
    #16;
  endtask : junk

  task automatic xfer(input logic [7:0] b, input int n, input int hh,
                      input int hl);
    for (int i = 0; i < n; i++) begin
      si = b[7-i];
      #32 sck = 1'b1;
      rx_byte = {rx_byte[6:0], so};
      if (i == hh) begin
        #16 hold_n = 1'b0;
        #16 sck = 1'b0;
        junk();
      end else begin
        #32 sck = 1'b0;
      end
      if (i == hl) begin
        hold_n = 1'b0;
        #16;
        junk();
      end
    end
  endtask : xfer

  task automatic recv(input int hl);
    xfer(8'h00, 8, -1, hl);
    rx_done = ~rx_done;
  endtask : recv

endmodule : spi_host

// file: tb/serial_eeprom_pin_control_tb.sv
`timescale 1ns/1ps
module serial_eeprom_pin_control_tb;
  import eeprom_pkg::*;

  localparam int unsigned TW = 200;
  logic        clk, rst_n, wp_n, sck, cs_n, si, hold_n;
  logic        so_o, so_oe, standby, rx_done;
  logic [7:0]  rx_byte, d0, d1;
  logic [12:0] a;
  logic [31:0] rs;
  logic [7:0]  expq[$];
  wire         so_w;
  int          failures, samples_checked, cyc;

  assign so_w = so_oe ? so_o : 1'bz;

  serial_eeprom_pin_control #(.TWC_CYCLES(TW)) dut_u (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe),
    .standby(standby));

  spi_host host_u (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so_w),
    .rx_byte(rx_byte), .rx_done(rx_done));

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  always @(rx_done) begin
    if (expq.size() > 0) begin
      check("read byte", expq.pop_front(), rx_byte);
    end
  end

  always @(posedge cs_n) begin
    #1;
    check("so_oe deselected", 8'h00, {7'h00, so_oe});
  end

  always @(negedge hold_n) begin
    #1;
    check("so_oe paused", 8'h00, {7'h00, so_oe});
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  task automatic cmd(input logic [7:0] op);
    host_u.sel();
    host_u.xfer(op, 8, -1, -1);
    host_u.frame_end();
    #160;
  endtask : cmd

  task automatic rdsr(input logic [7:0] e, input int hl);
    expq.push_back(e);
    host_u.sel();
    host_u.xfer(OP_RDSR, 8, -1, -1);
    host_u.recv(hl);
    host_u.frame_end();
    #160;
  endtask : rdsr

  task automatic wrsr(input logic [7:0] v);
    cmd(OP_WREN);
    host_u.sel();
    host_u.xfer(OP_WRSR, 8, -1, -1);
    host_u.xfer(v, 8, -1, -1);
    host_u.frame_end();
  endtask : wrsr

  task automatic rd(input logic [12:0] ad, input logic [7:0] e,
                    input int hh, input int hl);
    expq.push_back(e);
    host_u.sel();
    host_u.xfer(OP_READ, 8, -1, -1);
    host_u.xfer({3'h0, ad[12:8]}, 8, hh, -1);
    host_u.xfer(ad[7:0], 8, -1, -1);
    host_u.recv(hl);
    host_u.frame_end();
    #160;
  endtask : rd

  // Counts clk cycles from select rise until standby is reported.
  task automatic wait_wr(input logic busy);
    int   n;
    logic ok;
    n = 0;
    while (standby !== 1'b1 && n < TW + 50) begin
      @(negedge clk);
      n++;
    end
    if (busy) begin
      ok = n >= TW && n <= TW + 8;
      check("cycle length", 8'h01, {7'h00, ok});
    end else begin
      check("no cycle", 8'h01, {7'h00, n < 8});
    end
    #160;
  endtask : wait_wr

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    failures = 0;
    samples_checked = 0;
    cyc = 0;
    rs = 32'h22366340;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("standby idle", 8'h01, {7'h00, standby});
    cmd(OP_WREN);
    rdsr(8'h00, -1);
    cmd(OP_WREN);
    rdsr(8'h02, 3);
    $display("test wake-up and pause done");
    @(posedge clk) wp_n <= 1'b0;
    wrsr(8'h80);
    wait_wr(1'b1);
    rdsr(8'h80, -1);
    wrsr(8'h0C);
    wait_wr(1'b0);
    rdsr(8'h82, -1);
    @(posedge clk) wp_n <= 1'b1;
    wrsr(8'h00);
    #160;
    @(posedge clk) wp_n <= 1'b0;
    rdsr(8'h03, -1);
    repeat (TW) @(posedge clk);
    rdsr(8'h00, -1);
    $display("test protect pin done");
    rs = xs(rs);
    a = {rs[12:5], 5'h1F};
    d0 = rs[23:16];
    d1 = rs[31:24];
    cmd(OP_WREN);
    host_u.sel();
    host_u.xfer(OP_WRITE, 8, -1, -1);
    host_u.xfer({3'h0, a[12:8]}, 8, -1, -1);
    host_u.xfer(a[7:0], 8, -1, -1);
    host_u.xfer(d0, 8, -1, -1);
    host_u.xfer(d1, 8, -1, -1);
    host_u.frame_end();
    wait_wr(1'b1);
    rd(a, d0, 2, -1);
    rd({a[12:5], 5'h00}, d1, -1, 4);
    $display("test array write and read done");
    cmd(OP_WREN);
    host_u.sel();
    host_u.xfer(OP_WRITE, 8, -1, -1);
    host_u.xfer(8'h00, 8, -1, -1);
    host_u.xfer(8'h00, 8, -1, -1);
    host_u.xfer(8'hFF, 4, -1, -1);
    host_u.frame_end();
    wait_wr(1'b0);
    rdsr(8'h02, -1);
    cmd(OP_WRDI);
    rdsr(8'h00, -1);
    $display("test partial frame done");
    stop_test();
  end

endmodule : serial_eeprom_pin_control_tb
